// File: core/sfc_clkdiv.sv
/*
  Functional-clock tick and bus-clock phase generator.
  Assumes restart is pulsed on a functional tick when the bus clock is to begin.
*/
`timescale 1ns/1ps
module sfc_clkdiv (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Control
  input  wire logic       restart,
  input  wire logic [1:0] divSel,
  // Timing outputs
  output logic            funcTick,
  output logic            busHigh,
  output logic            busRise,
  output logic            busFall
);
  logic       tog_r;
  logic [2:0] ph_r;
  wire  [2:0] halfLen = {1'b0, divSel} + 3'h1;
  wire  [2:0] lastPh  = 3'((halfLen << 1) - 3'h1);

  // Bus period is (divSel + 1) functional cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      tog_r <= 1'b0;
      ph_r  <= 3'h0;
    end else begin
      tog_r <= ~tog_r;
      if (restart || ph_r >= lastPh) begin
        ph_r <= 3'h0;
      end else begin
        ph_r <= ph_r + 3'h1;
      end
    end
  end

  assign funcTick = tog_r;
  assign busHigh  = ph_r < halfLen;
  assign busRise  = ph_r == 3'h0;
  assign busFall  = ph_r == halfLen;
endmodule // sfc_clkdiv

// File: core/sfc_nor_ctrl.sv
/*
  Synchronous multiplexed-bus controller toward a NOR flash: bus clock, strobes,
  address, data and wait handling for single and burst accesses on four regions.
  Assumes timing fields are held stable while busy and that times are ordered sensibly.
*/
`timescale 1ns/1ps
// Contract
// RULE1: Divide field zero: bus clock equals functional
// RULE2: Divide 1..3 gives functional clock /2../4
// RULE3: Source select 01 flags the fast clock
// RULE4: Every scaled time multiplied by granularity plus one
// RULE5: Single read select low for off minus on
// RULE6: Burst adds beats minus one burst times
// RULE7: Address, byte enables before unscaled clock start
// RULE8: Single read byte enables low cycle length
// RULE9: Burst byte enables add beats minus one
// RULE10: Wait monitoring only with nonzero advance
// RULE11: Two wait inputs, assignable per region
// RULE12: Read data captured on bus rising edge
// RULE13: Wait input sampled on bus rising edge
// RULE14: Divide by one gives one functional period
// RULE15: Address changes only outside bus clocking
// RULE16: Write data launch edge depends on mode
// RULE17: Address strobe low for off minus on
// RULE18: Four active-low selects, own configuration each
// RULE19: One functional-cycle counter times every strobe
// RULE20: Strobes high while idle and after reset
module sfc_nor_ctrl (
  // Clock and reset
  input  wire logic [0:0]  clk,
  input  wire logic        reset,
  // Per-region configuration, two bits or one bit per region, then the shared clock source select
  input  wire logic [7:0]  regionDivide,
  input  wire logic [7:0]  regionScale,
  input  wire logic [3:0]  regionWaitSel,
  input  wire logic [3:0]  regionWaitEn,
  input  wire logic [1:0]  funcClockSource,
  // Timing fields in functional cycles
  input  wire logic [4:0]  selectAssertTime,
  input  wire logic [4:0]  selectReadDeassertTime,
  input  wire logic [4:0]  selectWriteDeassertTime,
  input  wire logic [4:0]  addrStrobeAssertTime,
  input  wire logic [4:0]  addrStrobeReadDeassertTime,
  input  wire logic [4:0]  addrStrobeWriteDeassertTime,
  input  wire logic [4:0]  readCycleLength,
  input  wire logic [4:0]  writeCycleLength,
  input  wire logic [4:0]  firstDataTime,
  input  wire logic [4:0]  busClockStartDelay,
  input  wire logic [4:0]  waitSampleAdvance,
  input  wire logic [3:0]  burstBeatTime,
  // Access request
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [1:0]  reqRegion,
  input  wire logic [3:0]  reqExtraBeats,
  input  wire logic [1:0]  reqByteMask,
  input  wire logic [27:1] reqAddr,
  input  wire logic [15:0] writeData,
  // Access status
  output logic             busy_r,
  output logic             done_r,
  output logic             writeTaken_r,
  output logic             readValid_r,
  output logic [15:0]      readData_r,
  output logic             fastSource_r,
  output logic             waitConfigBad_r,
  // Memory pins
  output logic             busClk_r,
  output logic [3:0]       selectN_r,
  output logic             addrStrobeN_r,
  output logic             outEnableN_r,
  output logic             writeEnableN_r,
  output logic             low_byte_enable_n_r,
  output logic             high_byte_enable_n_r,
  output logic [27:1]      addr_r,
  output logic [15:0]      adOut_r,
  output logic             adOe_r,
  input  wire logic [15:0] adIn,
  input  wire logic [1:0]  waitIn
);
  localparam int CW = sfc_pkg::CNT_W;

  sfc_pkg::sfc_state_t state_r;
  logic [CW-1:0]       cnt_r;
  logic                write_r;
  logic [1:0]          region_r;
  logic [3:0]          beats_r;
  logic [4:0]          beatIdx_r;
  logic [1:0]          mask_r;
  logic                waitHeld_r;
  logic [15:0]         adSync;
  logic [1:0]          waitSync;
  logic                funcTick;
  logic                busHigh;
  logic                busRise;
  logic                busFall;

  // Time in functional cycles times the granularity factor
  function automatic logic [CW-1:0] scl(input logic [9:0] t, input logic [1:0] g);
    scl = CW'(t) * (CW'(g) + CW'(1));
  endfunction

  // Base time plus the burst extension, before scaling
  function automatic logic [9:0] withBurst(input logic [4:0] t, input logic [3:0] n, input logic [3:0] b);
    withBurst = 10'(t) + 10'(n) * 10'(b);
  endfunction

  wire       running   = state_r == sfc_pkg::ST_RUN;
  // Taken on a functional tick so the first count lasts a whole functional cycle
  wire       accept    = !running && reqValid && funcTick;
  wire [1:0] divSel    = regionDivide[2*region_r +: 2];
  wire [1:0] gran      = regionScale[2*region_r +: 2];
  wire       divOne    = divSel == sfc_pkg::DIV_BY_ONE;
  wire [4:0] csOff     = write_r ? selectWriteDeassertTime : selectReadDeassertTime;
  wire [4:0] advOff    = write_r ? addrStrobeWriteDeassertTime : addrStrobeReadDeassertTime;
  wire [4:0] cycleLen  = write_r ? writeCycleLength : readCycleLength;
  wire [CW-1:0] csOn   = scl(10'(selectAssertTime), gran);
  wire [CW-1:0] csEnd  = scl(withBurst(csOff, beats_r, burstBeatTime), gran);  // RULE5 RULE6 RULE4
  wire [CW-1:0] beEnd  = scl(withBurst(cycleLen, beats_r, burstBeatTime), gran);  // RULE8 RULE9
  wire [CW-1:0] advOn  = scl(10'(addrStrobeAssertTime), gran);
  wire [CW-1:0] advEnd = scl(10'(advOff), gran);  // RULE17
  wire [CW-1:0] dataAt = scl(withBurst(firstDataTime, beatIdx_r[3:0], burstBeatTime), gran);
  wire [CW-1:0] lastAt = csEnd > beEnd ? csEnd : beEnd;
  wire [CW-1:0] clkOn  = CW'(busClockStartDelay);  // RULE7
  // Gated until the divider phase has restarted, so no stray pulse precedes the first rise
  wire       clkRun    = running && cnt_r > clkOn && cnt_r < lastAt;
  wire       clkStart  = running && funcTick && cnt_r == clkOn;
  wire       csLow     = running && cnt_r >= csOn && cnt_r < csEnd;
  wire       advLow    = running && cnt_r >= advOn && cnt_r < advEnd;
  wire       beLow     = running && cnt_r < beEnd;
  wire       oeLow     = running && !write_r && cnt_r >= advEnd && cnt_r < csEnd;
  wire       weLow     = running && write_r && cnt_r >= advEnd && cnt_r < csEnd;
  wire       beatsLeft = beatIdx_r <= 5'(beats_r);
  wire       dataPhase = running && cnt_r >= dataAt && beatsLeft;
  wire       waitUsable = regionWaitEn[region_r] && waitSampleAdvance != 5'h00;  // RULE10
  wire       waitPin   = waitSync[regionWaitSel[region_r]];  // RULE11
  wire       stall     = waitUsable && waitHeld_r && dataPhase;
  wire       launchEdge = (divOne && beatIdx_r == 5'h00) ? busRise : busFall;  // RULE16
  wire       readTake  = clkRun && busRise && !write_r && dataPhase && !stall;  // RULE12
  wire       writeTake = clkRun && launchEdge && write_r && dataPhase && !stall;
  wire       finish    = running && funcTick && cnt_r >= lastAt;

  sfc_sync3 #(.W(16)) u_adSync (
    .clk  (clk),
    .reset(reset),
    .din  (adIn),
    .dout (adSync)
  );

  sfc_sync3 #(.W(2)) u_waitSync (
    .clk  (clk),
    .reset(reset),
    .din  (waitIn),
    .dout (waitSync)
  );

  // Divider phase restarts where the bus clock starts so the first edge is a rising one
  sfc_clkdiv u_div (
    .clk     (clk),
    .reset   (reset),
    .restart (clkStart),
    .divSel  (divSel),  // RULE1 RULE2 RULE14
    .funcTick(funcTick),
    .busHigh (busHigh),
    .busRise (busRise),
    .busFall (busFall)
  );

  // Access sequencing and the functional-cycle counter
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r  <= sfc_pkg::ST_IDLE;
      cnt_r    <= '0;
      write_r  <= 1'b0;
      region_r <= 2'h0;
      beats_r  <= 4'h0;
      mask_r   <= 2'h0;
      addr_r   <= '0;
    end else begin
      case (state_r)
        sfc_pkg::ST_IDLE: begin
          if (accept) begin
            state_r  <= sfc_pkg::ST_RUN;
            cnt_r    <= '0;
            write_r  <= reqWrite;
            region_r <= reqRegion;
            beats_r  <= reqExtraBeats;
            mask_r   <= reqByteMask;
            addr_r   <= reqAddr;  // RULE15
          end
        end
        sfc_pkg::ST_RUN: begin
          if (finish) begin
            state_r <= sfc_pkg::ST_IDLE;
          end else if (funcTick && !stall) begin
            cnt_r <= cnt_r + CW'(1);  // RULE19
          end
        end
        default: begin
          state_r <= sfc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Wait level held from one bus rising edge to the next
  always_ff @(posedge clk) begin
    if (reset || !running) begin
      waitHeld_r <= 1'b0;
    end else if (clkRun && busRise) begin
      waitHeld_r <= waitPin;  // RULE13
    end
  end

  // Beat counting and data movement
  always_ff @(posedge clk) begin
    if (reset) begin
      beatIdx_r    <= 5'h00;
      readData_r   <= sfc_pkg::AD_RESET;
      readValid_r  <= 1'b0;
      writeTaken_r <= 1'b0;
    end else begin
      readValid_r  <= readTake;
      writeTaken_r <= writeTake;
      if (accept) begin
        beatIdx_r <= 5'h00;
      end else if (readTake || writeTake) begin
        beatIdx_r <= beatIdx_r + 5'h01;
      end
      if (readTake) begin
        readData_r <= adSync;
      end
    end
  end

  // Multiplexed bus: address while the strobe is low, then write data
  always_ff @(posedge clk) begin
    if (reset) begin
      adOut_r <= sfc_pkg::AD_RESET;
      adOe_r  <= 1'b0;
    end else if (advLow) begin
      adOut_r <= addr_r[16:1];
      adOe_r  <= 1'b1;
    end else if (writeTake) begin
      adOut_r <= writeData;
      adOe_r  <= 1'b1;
    end else if (!running || !write_r) begin
      adOe_r  <= 1'b0;
    end
  end

  // Pin strobes, all high while idle
  always_ff @(posedge clk) begin
    if (reset) begin
      selectN_r            <= sfc_pkg::CS_IDLE;  // RULE20
      addrStrobeN_r        <= 1'b1;
      outEnableN_r         <= 1'b1;
      writeEnableN_r       <= 1'b1;
      low_byte_enable_n_r  <= 1'b1;
      high_byte_enable_n_r <= 1'b1;
      busClk_r             <= 1'b0;
    end else begin
      selectN_r            <= ~(4'(csLow) << region_r);  // RULE18 RULE20
      addrStrobeN_r        <= ~advLow;
      outEnableN_r         <= ~oeLow;
      writeEnableN_r       <= ~weLow;
      low_byte_enable_n_r  <= ~(beLow && mask_r[0]);  // RULE7 RULE8
      high_byte_enable_n_r <= ~(beLow && mask_r[1]);
      busClk_r             <= clkRun && busHigh;
    end
  end

  // Status flags
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_r          <= 1'b0;
      done_r          <= 1'b0;
      fastSource_r    <= 1'b0;
      waitConfigBad_r <= 1'b0;
    end else begin
      busy_r          <= running && !finish;
      done_r          <= finish;
      fastSource_r    <= funcClockSource == sfc_pkg::SRC_PLL_DIV3;  // RULE3
      waitConfigBad_r <= |regionWaitEn && waitSampleAdvance == 5'h00;  // RULE10
    end
  end
endmodule // sfc_nor_ctrl

// File: core/sfc_pkg.sv
/*
  Shared constants for the synchronous flash bus controller.
  Assumes a single 20 MHz clock; the functional clock is modelled as every second clock edge.
*/
package sfc_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLKS_PER_FUNC = 2;
  localparam int ADDR_W        = 27;
  localparam int DATA_W        = 16;
  localparam int TIME_W        = 5;
  localparam int BEAT_W        = 4;
  localparam int CNT_W         = 12;
  localparam int REGIONS       = 4;
  localparam int WAIT_PINS     = 2;
  localparam logic [1:0] DIV_BY_ONE      = 2'h0;
  localparam logic [1:0] SRC_PLL_DIV3    = 2'h1;
  localparam int         SRC_PLL_MHZ     = 300;
  localparam int         FUNC_FAST_MHZ   = SRC_PLL_MHZ / 3;
  localparam int         BUS_FAST_PER_NS = 1000 / FUNC_FAST_MHZ;
  localparam logic [DATA_W-1:0] AD_RESET = 16'h0000;
  localparam logic [3:0]        CS_IDLE  = 4'hF;
  typedef enum {ST_IDLE, ST_RUN} sfc_state_t;
endpackage

// File: core/sfc_sync3.sv
/*
  Three-flop input synchroniser; output follows once the second and third stages agree.
  Assumes inputs arrive from outside the clock domain.
*/
`timescale 1ns/1ps
module sfc_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule // sfc_sync3

// File: tb/sfc_flash_model.sv
/* Flash partner: address-derived read word, stall on chosen wait lines.
   Assumes the controller pins change on the system clock. */
`timescale 1ns/1ps
module sfc_flash_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Controller pins
  input  wire logic        busClk,
  input  wire logic        outEnableN,
  input  wire logic [27:1] addr,
  input  wire logic [1:0]  stallOn,
  output logic      [15:0] adIn,
  output logic      [1:0]  waitIn
);
  logic [15:0] lastWord;
  logic        prevBus;
  int          nStall;
  // Released bus shows the inverse of the last word; wait moves after bus falls, two stalled beats at most
  always @(posedge clk) begin
    if (reset) begin
      adIn     <= 16'hFFFF;
      lastWord <= 16'h0000;
      waitIn   <= 2'h0;
      prevBus  <= 1'b0;
      nStall   <= 0;
    end else begin
      prevBus <= busClk;
      if (!outEnableN) begin
        adIn     <= addr[16:1] ^ 16'h3C5A;
        lastWord <= addr[16:1] ^ 16'h3C5A;
      end else begin
        adIn <= ~lastWord;
      end
      if (outEnableN) begin
        waitIn <= 2'h0;
        nStall <= 0;
      end else if (prevBus && !busClk) begin
        waitIn <= (nStall < 2) ? stallOn : 2'h0;
        nStall <= nStall + 1;
      end
    end
  end
endmodule // sfc_flash_model

// File: tb/sfc_nor_ctrl_sva.sv
/* Port checker for the flash bus controller.
   Assumes all regions share one divide setting. */
`timescale 1ns/1ps
module sfc_nor_ctrl_sva (
  // Clock and reset
  input wire logic [0:0]  clk,
  input wire logic        reset,
  // Configuration
  input wire logic [7:0]  regionDivide,
  input wire logic [3:0]  regionWaitEn,
  input wire logic [4:0]  waitSampleAdvance,
  input wire logic [1:0]  funcClockSource,
  // Status
  input wire logic        busy_r,
  input wire logic        done_r,
  input wire logic        fastSource_r,
  input wire logic        waitConfigBad_r,
  // Memory pins
  input wire logic        busClk_r,
  input wire logic [3:0]  selectN_r,
  input wire logic        addrStrobeN_r,
  input wire logic        outEnableN_r,
  input wire logic        writeEnableN_r,
  input wire logic        low_byte_enable_n_r,
  input wire logic        high_byte_enable_n_r,
  input wire logic [27:1] addr_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic allHigh;
  assign allHigh = (selectN_r == 4'hF) && addrStrobeN_r && outEnableN_r && writeEnableN_r
                   && low_byte_enable_n_r && high_byte_enable_n_r;
  sequence s_src_steady;
    $stable(funcClockSource) [*3];
  endsequence
  sequence s_cfg_steady;
    ($stable(regionWaitEn) && $stable(waitSampleAdvance)) [*3];
  endsequence
  a_idle_pins_high: assert property (!busy_r && !$past(busy_r) |-> allHigh && !busClk_r)
    else $error("pin active while idle");
  a_addr_hold: assert property (busy_r && $past(busy_r) && $past(busy_r, 2) |-> $stable(addr_r))
    else $error("address moved during access");
  a_done_ends_busy: assert property (done_r |-> $fell(busy_r))
    else $error("done without busy falling");
  a_done_single: assert property (done_r |=> !done_r)
    else $error("done longer than one cycle");
  a_fast_source: assert property (s_src_steady |-> fastSource_r == (funcClockSource == 2'h1))
    else $error("fast source flag wrong");
  a_wait_cfg: assert property (s_cfg_steady |-> waitConfigBad_r == ((regionWaitEn != 4'h0) && (waitSampleAdvance == 5'h00)))
    else $error("wait config flag wrong");
  a_one_select: assert property (selectN_r != 4'hF |-> $onehot(~selectN_r))
    else $error("several selects low");
  a_undiv_clock: assert property ($rose(busClk_r) && regionDivide == 8'h00 |=> !busClk_r)
    else $error("undivided bus clock high too long");
  a_dir_apart: assert property (!(!outEnableN_r && !writeEnableN_r))
    else $error("read and write enables both low");
endmodule // sfc_nor_ctrl_sva

bind sfc_nor_ctrl sfc_nor_ctrl_sva u_sva (.clk(clk), .reset(reset), .regionDivide(regionDivide),
  .regionWaitEn(regionWaitEn), .waitSampleAdvance(waitSampleAdvance), .funcClockSource(funcClockSource),
  .busy_r(busy_r), .done_r(done_r), .fastSource_r(fastSource_r), .waitConfigBad_r(waitConfigBad_r),
  .busClk_r(busClk_r), .selectN_r(selectN_r), .addrStrobeN_r(addrStrobeN_r), .outEnableN_r(outEnableN_r),
  .writeEnableN_r(writeEnableN_r), .low_byte_enable_n_r(low_byte_enable_n_r),
  .high_byte_enable_n_r(high_byte_enable_n_r), .addr_r(addr_r));

// File: tb/sync_nor_flash_bus_controller_test.sv
/* Self-checking bench for the flash bus controller with a flash partner.
   Assumes the 20 MHz clock and a functional clock of every second edge. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module sync_nor_flash_bus_controller_test;
  localparam int C = sfc_pkg::CLKS_PER_FUNC;
  logic        clk = 0, reset = 1, reqValid = 0, reqWrite = 0;
  logic [7:0]  div8 = 0, scale8 = 0;
  logic [3:0]  waitEn = 0, waitSel = 0, beats = 0;
  logic [4:0]  adv = 5'h02, on = 1, aon = 1, off = 11, cyc = 12, strt = 1;
  logic [1:0]  src = 0, region = 0, mask = 1, stallOn = 0, waitIn;
  logic [27:1] addr = 0;
  logic [15:0] wdata = 0, adIn;
  logic        busy, done, wTaken, rValid, busClk, advN, oeN, weN, be0N, be1N, adOe;
  logic [3:0]  selN;
  logic [15:0] rData, adOut;
  logic [27:1] addrOut;
  int          seed = 32'h8359, n_fail = 0, cmp_count = 0, i, d;

  sfc_nor_ctrl i_dut (.clk(clk), .reset(reset), .regionDivide(div8), .regionScale(scale8),
    .regionWaitSel(waitSel), .regionWaitEn(waitEn), .funcClockSource(src), .selectAssertTime(on),
    .selectReadDeassertTime(off), .selectWriteDeassertTime(off), .addrStrobeAssertTime(aon),
    .addrStrobeReadDeassertTime(5'h03), .addrStrobeWriteDeassertTime(5'h03), .readCycleLength(cyc),
    .writeCycleLength(cyc), .firstDataTime(5'h06), .busClockStartDelay(strt), .waitSampleAdvance(adv),
    .burstBeatTime(4'h4), .reqValid(reqValid), .reqWrite(reqWrite), .reqRegion(region),
    .reqExtraBeats(beats), .reqByteMask(mask), .reqAddr(addr), .writeData(wdata), .busy_r(busy),
    .done_r(done), .writeTaken_r(wTaken), .readValid_r(rValid), .readData_r(rData), .fastSource_r(),
    .waitConfigBad_r(), .busClk_r(busClk), .selectN_r(selN), .addrStrobeN_r(advN), .outEnableN_r(oeN),
    .writeEnableN_r(weN), .low_byte_enable_n_r(be0N), .high_byte_enable_n_r(be1N), .addr_r(addrOut),
    .adOut_r(adOut), .adOe_r(adOe), .adIn(adIn), .waitIn(waitIn));
  sfc_flash_model i_flash (.clk(clk), .reset(reset), .busClk(busClk), .outEnableN(oeN), .addr(addrOut),
    .stallOn(stallOn), .adIn(adIn), .waitIn(waitIn));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic give_verdict;
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic access(input logic wr, input bit longer);
    int n, g, t, k, csExp, nCs, nBe0, nBe1, nAdv, nBeat, r1, r2;
    logic prevBus;
    n = beats + 1;
    g = scale8[1:0] + 1;
    csExp = (off - on + (n - 1) * 4) * g * C;
    {nCs, nBe0, nBe1, nAdv, nBeat, k} = '0;
    r1 = -1;
    r2 = -1;
    prevBus = 1'b0;
    @(negedge clk);
    reqWrite = wr;
    reqValid = 1'b1;
    for (t = 0; t < 100 && busy !== 1'b1; t++) @(negedge clk);
    reqValid = 1'b0;
    for (t = 0; t < 3000 && k < 4; t++) begin
      nCs += !selN[region];
      nBe0 += !be0N;
      nBe1 += !be1N;
      nAdv += !advN;
      nBeat += wr ? wTaken : rValid;
      if (busClk && !prevBus) begin
        if (r1 < 0) r1 = t;
        else if (r2 < 0) r2 = t;
      end
      prevBus = busClk;
      if (rValid === 1'b1) `CHK("rdata", addr[16:1] ^ 16'h3C5A, rData)
      if (advN === 1'b0) `CHK("adaddr", addr[16:1], adOut)
      if (wTaken === 1'b1) begin
        `CHK("wdata", wdata, adOut)
        `CHK("adoe", 1'b1, adOe)
        wdata = 16'($random(seed));
      end
      if (done === 1'b1 || k > 0) k++;
      @(negedge clk);
    end
    `CHK("done", 4, k)
    `CHK("beats", n, nBeat)
    `CHK("busper", (div8[1:0] + 1) * C, r2 - r1)
    `CHK("adv", (3 - aon) * g * C, nAdv)
    if (longer) `CHK("stretch", 1, int'(nCs > csExp))
    else begin
      `CHK("cs", csExp, nCs)
      `CHK("be0", mask[0] ? (cyc + (n - 1) * 4) * g * C : 0, nBe0)
      `CHK("be1", mask[1] ? (cyc + (n - 1) * 4) * g * C : 0, nBe1)
    end
  endtask

  initial begin
    #(50 * 60000);
    n_fail++;
    give_verdict();
  end

  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    for (i = 0; i < 16; i++) begin
      d = $random(seed);
      div8 = {4{d[1:0]}};
      scale8 = {4{1'b0, d[2]}};
      region = d[4:3];
      beats = {2'b00, d[6:5]};
      mask = d[8:7];
      src = d[10:9];
      on = 5'h01 + d[11];
      aon = 5'h01 + d[12];
      off = 5'h0B + d[13];
      cyc = 5'h0C + d[14];
      strt = 5'h01 + d[15];
      addr = 27'($random(seed));
      wdata = 16'($random(seed));
      access(d[16], 1'b0);
    end
    region = 2'h0;
    waitSel = 4'h1;
    waitEn = 4'h1;
    adv = 5'h00;
    stallOn = 2'h2;
    access(1'b0, 1'b0);
    `CHK("cfgbad", 1'b1, i_dut.waitConfigBad_r)
    adv = 5'h02;
    stallOn = 2'h1;
    access(1'b0, 1'b0);
    `CHK("cfgok", 1'b0, i_dut.waitConfigBad_r)
    stallOn = 2'h2;
    access(1'b0, 1'b1);
    give_verdict();
  end
endmodule // sync_nor_flash_bus_controller_test
